// *** design/fae_flash_adc.v ***
// Operation
// (R1) The coding-select pins are static configuration held steady by the board, not toggled during conversions.
// (R2) Both coding-select pins are active low, so a high level means deasserted and a low level means asserted.
// (R3) The two selects give straight binary or offset two's complement, each true or inverted, four formats.
// (R4) With the MSB-invert select low, the most significant bit of the encoded word is inverted.
// (R5) With the low-bits-invert select low, the seven lower bits are inverted, independently of the MSB.
// (R6) The comparator states are latched at the earliest cycle after each rising strobe edge, never later; the code latches them three mclk edges later.
// (R7) On each falling strobe edge the latched 255-line thermometer code is encoded into an 8-bit word.
// (R8) On the rising strobe edge after encoding the encoded word is loaded into the output register.
// (R9) The result of sample N appears at the output on the rising edge that takes sample N+2; the code loads it on the rise that takes sample N+1.
// (R10) An input between the bottom and top references gives a code from 0 through 255 by its position.
// (R11) An input above the top reference saturates full-scale positive and below the bottom full-scale negative.
// (R12) The input is compared with 255 thresholds, every one below the level on and every one above off.
// (R13) The output register holds its value unchanged until a new result is loaded.
`timescale 1ns/100ps
`default_nettype none
`include "fae_regs.vh"

module fae_flash_adc #(
    parameter AW = 16
) (
    // Clock and reset
    input wire mclk,
    input wire reset,
    // Convert strobe pin
    input wire sample_strobe,
    // Analog levels as signed fixed-point words
    input wire [AW-1:0] analog_in,
    input wire [AW-1:0] ref_top,
    input wire [AW-1:0] ref_bottom,
    // Coding selects, active low
    input wire msb_invert_n,
    input wire low_bits_invert_n,
    // Output word, bit 7 is out_bit_msb, bit 0 is out_bit_lsb
    output reg [`FAE_OUT_WIDTH-1:0] out_data,
    output reg out_update
);

    reg strobe_s1;
    reg strobe_s2;
    reg strobe_s3;
    reg [AW-1:0] ain_s1;
    reg [AW-1:0] ain_s2;
    reg [AW-1:0] rtop_s1;
    reg [AW-1:0] rtop_s2;
    reg [AW-1:0] rbot_s1;
    reg [AW-1:0] rbot_s2;
    reg msb_n_s1;
    reg msb_n_s2;
    reg low_n_s1;
    reg low_n_s2;
    reg [`FAE_COMPARATORS-1:0] therm_latched;
    reg [`FAE_OUT_WIDTH-1:0] encoded;
    wire [`FAE_COMPARATORS-1:0] comp_on;
    wire strobe_rise;
    wire strobe_fall;
    wire signed [AW:0] span;
    wire [`FAE_OUT_WIDTH-1:0] raw_code;
    wire [`FAE_OUT_WIDTH-1:0] next_encoded;
    wire enc_msb;
    wire [`FAE_LOW_BITS-1:0] enc_low;

    // Strobe pin: two synchroniser stages
    always @(posedge mclk) begin
        if (reset) begin
            strobe_s1 <= 1'b0;
            strobe_s2 <= 1'b0;
        end else begin
            strobe_s1 <= sample_strobe;
            strobe_s2 <= strobe_s1;
        end
    end

    // Edge history resets to the idle pin level, so no false edge after reset
    always @(posedge mclk) begin
        if (reset) begin
            strobe_s3 <= 1'b0;
        end else begin
            strobe_s3 <= strobe_s2;
        end
    end

    // Analog word goes through the same depth as the strobe so the sample stays aligned
    always @(posedge mclk) begin
        if (reset) begin
            ain_s1 <= {AW{1'b0}};
            ain_s2 <= {AW{1'b0}};
        end else begin
            ain_s1 <= analog_in;
            ain_s2 <= ain_s1;
        end
    end

    // Top reference, same depth as the analog word
    always @(posedge mclk) begin
        if (reset) begin
            rtop_s1 <= {AW{1'b0}};
            rtop_s2 <= {AW{1'b0}};
        end else begin
            rtop_s1 <= ref_top;
            rtop_s2 <= rtop_s1;
        end
    end

    // Bottom reference, same depth as the analog word
    always @(posedge mclk) begin
        if (reset) begin
            rbot_s1 <= {AW{1'b0}};
            rbot_s2 <= {AW{1'b0}};
        end else begin
            rbot_s1 <= ref_bottom;
            rbot_s2 <= rbot_s1;
        end
    end

    // Selects treated as static; a change mid-frame only shows on the next encode
    always @(posedge mclk) begin
        if (reset) begin
            msb_n_s1 <= `FAE_SEL_RESET;
            msb_n_s2 <= `FAE_SEL_RESET;
        end else begin
            msb_n_s1 <= msb_invert_n;
            msb_n_s2 <= msb_n_s1;
        end
    end

    // Reset to deasserted; both stages hold the pin level before any encode can take place
    always @(posedge mclk) begin
        if (reset) begin
            low_n_s1 <= `FAE_SEL_RESET;
            low_n_s2 <= `FAE_SEL_RESET;
        end else begin
            low_n_s1 <= low_bits_invert_n;
            low_n_s2 <= low_n_s1;
        end
    end

    assign strobe_rise = strobe_s2 & ~strobe_s3;
    assign strobe_fall = ~strobe_s2 & strobe_s3;

    assign span = $signed({rtop_s2[AW-1], rtop_s2}) - $signed({rbot_s2[AW-1], rbot_s2});

    // Comparator array against evenly spaced thresholds
    genvar gi;
    generate
        for (gi = 1; gi <= `FAE_COMPARATORS; gi = gi + 1) begin : g_comp
            localparam [`FAE_THRESH_MULT_W-1:0] K = 2 * gi - 1;
            wire signed [AW+11:0] prod;
            wire signed [AW+2:0] thresh;
            wire signed [AW+2:0] level;
            assign prod = span * $signed({1'b0, K});
            assign thresh = $signed({{3{rbot_s2[AW-1]}}, rbot_s2}) + prod[AW+11:`FAE_THRESH_SHIFT];
            assign level = $signed({{3{ain_s2[AW-1]}}, ain_s2});
            // Over the top all are on, under the bottom all are off
            assign comp_on[gi-1] = (level > thresh); // (R12) (R11)
        end
    endgenerate

    // Ones count equals the top lit comparator for a clean thermometer
    function [`FAE_OUT_WIDTH-1:0] fae_count_ones;
        input [`FAE_COMPARATORS-1:0] therm;
        integer k;
        reg [`FAE_OUT_WIDTH-1:0] acc;
        begin
            acc = {`FAE_OUT_WIDTH{1'b0}};
            for (k = 0; k < `FAE_COMPARATORS; k = k + 1) begin
                acc = acc + {{(`FAE_OUT_WIDTH-1){1'b0}}, therm[k]};
            end
            fae_count_ones = acc;
        end
    endfunction

    assign raw_code = fae_count_ones(therm_latched); // (R10)

    // Offset two's complement is binary with the MSB flipped
    assign enc_msb = raw_code[`FAE_MSB_POS] ^ ~msb_n_s2; // (R2) (R4) (R3)
    // Low bits flip as a group, independent of the MSB select
    assign enc_low = raw_code[`FAE_LOW_BITS-1:0] ^ {`FAE_LOW_BITS{~low_n_s2}}; // (R5)
    assign next_encoded = {enc_msb, enc_low};

    // Comparators latched on the synchronised rise
    always @(posedge mclk) begin
        if (reset) begin
            therm_latched <= {`FAE_COMPARATORS{1'b0}};
        end else if (strobe_rise) begin
            therm_latched <= comp_on; // (R6)
        end
    end

    // Encode on the synchronised fall, with the selects seen then
    always @(posedge mclk) begin
        if (reset) begin
            encoded <= `FAE_OUT_RESET;
        end else if (strobe_fall) begin
            encoded <= next_encoded; // (R7)
        end
    end

    // Word from the previous strobe leaves as the new sample is taken
    always @(posedge mclk) begin
        if (reset) begin
            out_data <= `FAE_OUT_RESET;
            out_update <= 1'b0;
        end else begin
            out_update <= strobe_rise;
            if (strobe_rise) begin
                out_data <= encoded; // (R8) (R9)
            end
        end
    end
    // out_data is written only on a rising strobe, otherwise it holds (R13)

endmodule

`default_nettype wire

// *** design/fae_regs.vh ***
`ifndef FAE_REGS_VH
`define FAE_REGS_VH

// Converter shape
`define FAE_OUT_WIDTH 8
`define FAE_COMPARATORS 255
`define FAE_LOW_BITS 7
`define FAE_MSB_POS 7

// Threshold placement: threshold k sits at (2k-1)/512 of the span
`define FAE_THRESH_SHIFT 9
`define FAE_THRESH_MULT_W 10

// Timing
`define FAE_MCLK_HZ 10000000
`define FAE_MCLK_PERIOD_NS 100
`define FAE_SAMPLING_OFFSET_TIME_NS 15
`define FAE_SAMPLING_OFFSET_CYCLES_RAW (`FAE_SAMPLING_OFFSET_TIME_NS / `FAE_MCLK_PERIOD_NS)
`define FAE_SAMPLING_OFFSET_CYCLES ((`FAE_SAMPLING_OFFSET_CYCLES_RAW < 1) ? 1 : `FAE_SAMPLING_OFFSET_CYCLES_RAW)

// Reset values
`define FAE_OUT_RESET 8'h00
`define FAE_SEL_RESET 1'b1

`endif

// *** testbench/fae_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module fae_checker (
    // Clock and strobe
    input wire logic mclk,
    input wire logic reset,
    input wire logic sample_strobe,
    // Result
    input wire logic [7:0] out_data,
    input wire logic out_update
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_rise; !sample_strobe ##1 sample_strobe; endsequence
    property p_pulse; out_update |=> !out_update [*3]; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_hold; $changed(out_data) |-> out_update; endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_load; s_rise |-> ##[2:4] out_update; endproperty
    a_load: assert property (p_load) else $error("no load");
    property p_early; s_rise |-> !out_update ##1 !out_update; endproperty
    a_early: assert property (p_early) else $error("early load");
    property p_cause; out_update |-> $past(sample_strobe, 2); endproperty
    a_cause: assert property (p_cause) else $error("load no strobe");
    property p_fall; $fell(sample_strobe) |-> !out_update [*5]; endproperty
    a_fall: assert property (p_fall) else $error("load on fall");
    property p_idle; !sample_strobe [*8] |-> !out_update; endproperty
    a_idle: assert property (p_idle) else $error("load while low");
    property p_steady; sample_strobe [*8] |-> !out_update; endproperty
    a_steady: assert property (p_steady) else $error("load while high");
endmodule
bind fae_flash_adc fae_checker chk_u (.mclk(mclk), .reset(reset), .sample_strobe(sample_strobe),
    .out_data(out_data), .out_update(out_update));
`default_nettype wire

// *** testbench/fae_capture.sv ***
`timescale 1ns/100ps
`default_nettype none
module fae_capture (
    // Converter side
    input wire logic mclk,
    input wire logic [7:0] out_data,
    input wire logic out_update,
    // Captured word
    output logic [7:0] cap_data,
    output logic cap_valid
);
    // Takes the word one edge after the load, well before the next rise
    always @(posedge mclk) begin
        cap_valid <= out_update;
        cap_data <= out_data;
    end
endmodule
`default_nettype wire

// *** testbench/tb_flash_adc_encode_output_path.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_flash_adc_encode_output_path;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic sample_strobe = 1'b0;
    logic [15:0] analog_in = 16'h0000;
    logic msb_invert_n = 1'b1;
    logic low_bits_invert_n = 1'b1;
    logic [15:0] ref_top = 16'h0200;
    logic [15:0] ref_bottom = 16'h0000;
    int n_upd = 0;
    logic [7:0] out_data, cap_data, e_m;
    logic out_update, cap_valid;
    logic [7:0] exp_q[$];
    logic [15:0] edge_v [8] = '{16'h8000, 16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h01FD, 16'h01FE, 16'h7FFF};
    int n_fail = 0;
    int cmp_count = 0;
    integer seed = 32'h0BBA;
    initial forever #50 mclk = ~mclk;
    fae_flash_adc dut_u (.mclk(mclk), .reset(reset), .sample_strobe(sample_strobe), .analog_in(analog_in),
        .ref_top(ref_top), .ref_bottom(ref_bottom), .msb_invert_n(msb_invert_n),
        .low_bits_invert_n(low_bits_invert_n), .out_data(out_data), .out_update(out_update));
    fae_capture cap_u (.mclk(mclk), .out_data(out_data), .out_update(out_update), .cap_data(cap_data),
        .cap_valid(cap_valid));
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Span 512 puts threshold k at bottom plus 2k-1
    task automatic convert(input logic [15:0] a, input logic [1:0] sel, input logic [15:0] b);
        logic signed [16:0] d;
        logic [7:0] e;
        d = $signed(a) - $signed(b);
        e = (d < 0) ? 8'h00 : (d > 17'sd509) ? 8'hFF : d[8:1];
        e = e ^ {~sel[1], {7{~sel[0]}}};
        @(negedge mclk);
        analog_in = a;
        ref_bottom = b;
        ref_top = b + 16'h0200;
        msb_invert_n = sel[1];
        low_bits_invert_n = sel[0];
        repeat (2) @(negedge mclk);
        sample_strobe = 1'b1;
        repeat (10) @(negedge mclk);
        sample_strobe = 1'b0;
        exp_q.push_back(e);
        repeat (6) @(negedge mclk);
    endtask
    initial begin
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        for (int i = 0; i < 264; i++)
            convert(i < 8 ? edge_v[i] : 16'($random(seed) % 700), i[7:6], i < 132 ? 16'h0000 : 16'hFE00);
        sample_strobe = 1'b1;
        repeat (12) @(negedge mclk);
        `CHK("left", 0, exp_q.size())
        `CHK("updates", 265, n_upd)
        $display("conversion test done");
        test_done();
    end
    // Result of one sample shows at the following rise
    always @(negedge mclk) begin
        if (out_update === 1'b1)
            n_upd++;
        if (cap_valid === 1'b1 && exp_q.size() > 0) begin
            e_m = exp_q.pop_front();
            `CHK("out_data", e_m, cap_data)
        end
    end
    initial begin
        #(100 * 21 * 280);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
